// ===== regmask_pkg.sv
// Constants shared by the regulator status and event mask block
`default_nettype none
package regmask_pkg;
   // ********************************************************
   // Register offsets
   // ********************************************************
   localparam logic [7:0] ADDR_LINREG_STATUS = 8'h1f;
   localparam logic [7:0] ADDR_MASK_A        = 8'h20;
   localparam logic [7:0] ADDR_MASK_B        = 8'h21;
   localparam logic [7:0] ADDR_FLAGS_A       = 8'h1a;
   localparam logic [7:0] ADDR_FLAGS_B       = 8'h1b;

   // ********************************************************
   // Field positions
   // ********************************************************
   localparam int LR1_EN_BIT   = 7;
   localparam int LR1_PG_BIT   = 6;
   localparam int LR1_ILIM_BIT = 4;
   localparam int LR0_EN_BIT   = 3;
   localparam int LR0_PG_BIT   = 2;
   localparam int LR0_ILIM_BIT = 0;
   localparam int PG_PIN_BIT   = 7;
   localparam int SYNC_BIT     = 4;
   localparam int THERM_BIT    = 2;
   localparam int MEAS_BIT     = 0;
   localparam int REGRST_BIT   = 0;

   // ********************************************************
   // Values after reset
   // ********************************************************
   localparam logic [7:0] STATUS_RESET  = 8'h00;
   localparam logic [7:0] MASK_A_RESET  = 8'h90;
   localparam logic [7:0] MASK_B_RESET  = 8'h01;
   localparam logic [7:0] FLAGS_RESET   = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
endpackage
`default_nettype wire

// ===== flag_if.sv
// Interface carrying masks, clears and latched flags between modules
`default_nettype none
interface flag_if;
   logic [7:0] mask_a;
   logic [7:0] mask_b;
   logic [7:0] clr_a;
   logic [7:0] clr_b;
   logic [7:0] flags_a;
   logic [7:0] flags_b;

   modport ctl (output mask_a, mask_b, clr_a, clr_b,
                input  flags_a, flags_b);
   modport flg (input  mask_a, mask_b, clr_a, clr_b,
                output flags_a, flags_b);
endinterface
`default_nettype wire

// ===== status_sampler.sv
// Registered copy of the raw linear regulator status bits
`default_nettype none
module status_sampler (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   input  wire logic       lr1_en,
   input  wire logic       lr1_bad,
   input  wire logic       lr1_ilim,
   input  wire logic       lr0_en,
   input  wire logic       lr0_bad,
   input  wire logic       lr0_ilim,
   output var  logic [7:0] status_r
);
   logic [7:0] status_nxt;

   // Raw tracking, nothing latched; reserved bits 5 and 1 stay zero
   always_comb begin
      status_nxt = 8'h00;
      status_nxt[regmask_pkg::LR1_EN_BIT]   = lr1_en;
      status_nxt[regmask_pkg::LR1_PG_BIT]   = lr1_bad;
      status_nxt[regmask_pkg::LR1_ILIM_BIT] = lr1_ilim;
      status_nxt[regmask_pkg::LR0_EN_BIT]   = lr0_en;
      status_nxt[regmask_pkg::LR0_PG_BIT]   = lr0_bad;
      status_nxt[regmask_pkg::LR0_ILIM_BIT] = lr0_ilim;
   end

   // One sample per enabled cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_r <= regmask_pkg::STATUS_RESET;
      end else if (ce) begin
         status_r <= status_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== event_flags.sv
// Latched interrupt flags with write-one-to-clear and mask gating
`default_nettype none
module event_flags (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic ce,
   input  wire logic ev_pg,
   input  wire logic ev_sync,
   input  wire logic ev_therm,
   input  wire logic ev_meas,
   input  wire logic ev_regrst,
   flag_if.flg       fl
);
   logic [7:0] ev_a;
   logic [7:0] ev_b;
   logic [7:0] flags_a_r;
   logic [7:0] flags_b_r;
   logic [7:0] flags_a_nxt;
   logic [7:0] flags_b_nxt;

   // Place each event at its flag position
   always_comb begin
      ev_a = 8'h00;
      ev_b = 8'h00;
      ev_a[regmask_pkg::PG_PIN_BIT] = ev_pg;
      ev_a[regmask_pkg::SYNC_BIT]   = ev_sync;
      ev_a[regmask_pkg::THERM_BIT]  = ev_therm;
      ev_a[regmask_pkg::MEAS_BIT]   = ev_meas;
      ev_b[regmask_pkg::REGRST_BIT] = ev_regrst;
   end

   // Mask stops only the setting of a flag; set beats a same-cycle clear
   assign flags_a_nxt = (flags_a_r & ~fl.clr_a) | (ev_a & ~fl.mask_a);
   assign flags_b_nxt = (flags_b_r & ~fl.clr_b) | (ev_b & ~fl.mask_b);
   assign fl.flags_a  = flags_a_r;
   assign fl.flags_b  = flags_b_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_a_r <= regmask_pkg::FLAGS_RESET;
         flags_b_r <= regmask_pkg::FLAGS_RESET;
      end else if (ce) begin
         flags_a_r <= flags_a_nxt;
         flags_b_r <= flags_b_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== regulator_status_and_event_masks.sv
// Linear regulator status, top event masks and interrupt output
//
// Summary of operation
// - Status bit 7 and bit 3 read 1 while regulator one or zero is enabled.
// - Bits 6 and 2 show raw voltage validity, 1 when invalid, unlatched.
// - Bits 4 and 0 show raw current limiting, 1 while the limit is active.
// - The status register is read-only, reads 0 after reset, bits 5,1 are 0.
// - Power-good pin mask at bit 7 of mask A resets to 1; 1 suppresses.
// - Clock-detection mask at bit 4 resets to 1; 1 suppresses its flag.
// - Thermal warning mask at bit 2 resets to 0; writing 1 suppresses.
// - Measurement-ready mask at bit 0 of mask A resets to 0; 1 suppresses.
// - Masks gate flag setting and irq; raw status bits keep tracking.
// - Register-reset mask bit 0 of mask B resets to 1 and reloads from OTP.
// - Reserved mask bits reset to 0 and are not meant for software.
// - Flags latch on their event; writing 1 clears, writing 0 keeps.
`default_nettype none
module regulator_status_and_event_masks (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   output var  logic       irq,
   input  wire logic       linreg1_enabled,
   input  wire logic       linreg0_enabled,
   input  wire logic       linreg1_voltage_invalid,
   input  wire logic       linreg0_voltage_invalid,
   input  wire logic       linreg1_current_limited,
   input  wire logic       linreg0_current_limited,
   input  wire logic       powergood_pin_event,
   input  wire logic       sync_clk_event,
   input  wire logic       thermal_warn_event,
   input  wire logic       load_meas_event,
   input  wire logic       reg_reset_req,
   input  wire logic       otp_regrst_mask
);
   // ********************************************************
   // Declarations
   // ********************************************************
   flag_if fl ();

   logic [7:0] linear_reg_status;
   logic [7:0] top_event_mask_a_r;
   logic [7:0] top_event_mask_b_r;
   logic [7:0] mask_a_nxt;
   logic [7:0] mask_b_nxt;
   logic       otp_loaded_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       irq_r;
   logic       irq_nxt;
   logic       sel_status;
   logic       sel_mask_a;
   logic       sel_mask_b;
   logic       sel_flags_a;
   logic       sel_flags_b;
   logic       reload;

   // Flags that are set and not currently masked
   function automatic logic live(input logic [7:0] flags,
                                 input logic [7:0] mask);
      live = |(flags & ~mask);
   endfunction

   // ********************************************************
   // Raw status and latched flags
   // ********************************************************
   // raw status sampled, never masked
   status_sampler u_status (
      .clk      (clk),
      .rstn     (rstn),
      .ce       (ce),
      .lr1_en   (linreg1_enabled),
      .lr1_bad  (linreg1_voltage_invalid),
      .lr1_ilim (linreg1_current_limited),
      .lr0_en   (linreg0_enabled),
      .lr0_bad  (linreg0_voltage_invalid),
      .lr0_ilim (linreg0_current_limited),
      .status_r (linear_reg_status)
   );

   event_flags u_flags (
      .clk       (clk),
      .rstn      (rstn),
      .ce        (ce),
      .ev_pg     (powergood_pin_event),
      .ev_sync   (sync_clk_event),
      .ev_therm  (thermal_warn_event),
      .ev_meas   (load_meas_event),
      .ev_regrst (reg_reset_req),
      .fl        (fl.flg)
   );

   // ********************************************************
   // Address decode
   // ********************************************************
   assign sel_status  = (reg_addr == regmask_pkg::ADDR_LINREG_STATUS);
   assign sel_mask_a  = (reg_addr == regmask_pkg::ADDR_MASK_A);
   assign sel_mask_b  = (reg_addr == regmask_pkg::ADDR_MASK_B);
   assign sel_flags_a = (reg_addr == regmask_pkg::ADDR_FLAGS_A);
   assign sel_flags_b = (reg_addr == regmask_pkg::ADDR_FLAGS_B);

   // write-one-to-clear strobes, zero bits leave flags alone
   assign fl.clr_a = (reg_wr && sel_flags_a) ? reg_wdata : 8'h00;
   assign fl.clr_b = (reg_wr && sel_flags_b) ? reg_wdata : 8'h00;
   assign fl.mask_a = top_event_mask_a_r;
   assign fl.mask_b = top_event_mask_b_r;

   // ********************************************************
   // Mask registers
   // ********************************************************
   // Reload on the first cycle after release and on a register reset
   assign reload = !otp_loaded_r || reg_reset_req;

   // defaults on register reset, else host write
   assign mask_a_nxt = reg_reset_req ? regmask_pkg::MASK_A_RESET :
                       (reg_wr && sel_mask_a) ? reg_wdata :
                       top_event_mask_a_r;

   // OTP copy overrides host writes whenever a reset reload runs
   always_comb begin
      mask_b_nxt = top_event_mask_b_r;
      if (reload) begin
         mask_b_nxt = regmask_pkg::MASK_B_RESET;
         mask_b_nxt[regmask_pkg::REGRST_BIT] = otp_regrst_mask;
      end else if (reg_wr && sel_mask_b) begin
         mask_b_nxt = reg_wdata;
      end
   end

   // Asynchronous reset loads constants; OTP level caught after release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         top_event_mask_a_r <= regmask_pkg::MASK_A_RESET;
         top_event_mask_b_r <= regmask_pkg::MASK_B_RESET;
         otp_loaded_r       <= 1'b0;
      end else if (ce) begin
         top_event_mask_a_r <= mask_a_nxt;
         top_event_mask_b_r <= mask_b_nxt;
         otp_loaded_r       <= 1'b1;
      end
   end

   // ********************************************************
   // Read path
   // ********************************************************
   // status is read-only; unmapped offsets read zero
   assign rdata_nxt = sel_status  ? linear_reg_status :
                      sel_mask_a  ? top_event_mask_a_r :
                      sel_mask_b  ? top_event_mask_b_r :
                      sel_flags_a ? fl.flags_a :
                      sel_flags_b ? fl.flags_b :
                      regmask_pkg::UNMAPPED_DATA;

   // Read data holds until the next read so the engine may shift it out
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= regmask_pkg::UNMAPPED_DATA;
      end else if (ce && reg_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   // ********************************************************
   // Interrupt output
   // ********************************************************
   // any latched flag not currently masked
   assign irq_nxt = live(fl.flags_a, top_event_mask_a_r) ||
                    live(fl.flags_b, top_event_mask_b_r);

   // Registered so the pin never glitches on decode changes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_r <= 1'b0;
      end else if (ce) begin
         irq_r <= irq_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq       = irq_r;
endmodule
`default_nettype wire

// ===== rs_monitor.sv
// Port assertions for the regulator status and event mask block
`default_nettype none
module rs_mon (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       ce,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       irq,
   input wire logic       linreg1_enabled,
   input wire logic       linreg0_enabled,
   input wire logic       linreg1_voltage_invalid,
   input wire logic       linreg0_voltage_invalid,
   input wire logic       linreg1_current_limited,
   input wire logic       linreg0_current_limited,
   input wire logic       powergood_pin_event,
   input wire logic       sync_clk_event,
   input wire logic       thermal_warn_event,
   input wire logic       load_meas_event,
   input wire logic       reg_reset_req,
   input wire logic       otp_regrst_mask
);
   timeunit 1ns;
   timeprecision 100ps;
   // **********
   // Mask mirror
   // **********
   logic [7:0] a_r;
   logic [7:0] b_r;
   logic       first_r;
   wire logic wr_a = reg_wr && reg_addr == 8'h20;
   wire logic wr_b = reg_wr && reg_addr == 8'h21;
   wire logic rd_st = reg_rd && reg_addr == 8'h1f;
   // Reload beats a host write, since the design drops that write
   wire logic [7:0] a_nxt = reg_reset_req ? 8'h90 : wr_a ? reg_wdata : a_r;
   wire logic [7:0] b_nxt = (first_r || reg_reset_req) ?
      {7'h00, otp_regrst_mask} : wr_b ? reg_wdata : b_r;
   wire logic [7:0] st_in = {linreg1_enabled, linreg1_voltage_invalid,
      1'b0, linreg1_current_limited, linreg0_enabled,
      linreg0_voltage_invalid, 1'b0, linreg0_current_limited};
   wire logic any_ev = powergood_pin_event || sync_clk_event ||
      thermal_warn_event || load_meas_event || reg_reset_req;
   // A mask change may expose an old flag, so it counts as a cause
   wire logic cause = (powergood_pin_event && !a_r[7]) ||
      (sync_clk_event && !a_r[4]) || (thermal_warn_event && !a_r[2]) ||
      (load_meas_event && !a_r[0]) || reg_reset_req || wr_a || wr_b;
   // Mirror follows the reset values and the first-cycle reload
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         a_r     <= 8'h90;
         b_r     <= 8'h01;
         first_r <= 1'b1;
      end else if (ce) begin
         a_r     <= a_nxt;
         b_r     <= b_nxt;
         first_r <= 1'b0;
      end
   end
   // **********
   // Assertions
   // **********
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_clear_all;
      reg_wr && reg_addr == regmask_pkg::ADDR_FLAGS_A && reg_wdata == 8'hff
      && !any_ev ##1 reg_wr && reg_addr == regmask_pkg::ADDR_FLAGS_B &&
      reg_wdata == 8'hff && !any_ev ##1 !any_ev;
   endsequence
   property p_ev_irq(ev, msk);
      // A frozen cycle neither latches the event nor updates irq
      ce && ev && !msk && !wr_a && !reg_reset_req ##1 ce |-> ##1 irq;
   endproperty
   chk_status_bits:
      assert property (rd_st |=> reg_rdata == $past(st_in, 2))
      else $error("status read differs from inputs");
   chk_status_rsvd:
      assert property (rd_st |=> !reg_rdata[5] && !reg_rdata[1])
      else $error("reserved status bit set");
   chk_mask_a_read:
      assert property (reg_rd && reg_addr == 8'h20 |=>
                       reg_rdata == $past(a_r))
      else $error("mask A read wrong");
   chk_mask_b_read:
      assert property (reg_rd && reg_addr == 8'h21 |=>
                       reg_rdata == $past(b_r))
      else $error("mask B read wrong");
   chk_therm_irq: assert property (p_ev_irq(thermal_warn_event, a_r[2]))
      else $error("thermal event gave no irq");
   chk_meas_irq: assert property (p_ev_irq(load_meas_event, a_r[0]))
      else $error("measurement event gave no irq");
   chk_irq_cause: assert property ($rose(irq) |-> $past(cause, 2))
      else $error("irq rose with no unmasked event");
   chk_irq_clear: assert property (s_clear_all |=> !irq)
      else $error("irq stayed after all flags cleared");
endmodule
`default_nettype wire

// ===== reg_host.sv
// Host model driving the register port one transfer per clock
`default_nettype none
module reg_host (
   input  wire logic       clk,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   output var  logic       reg_wr,
   output var  logic       reg_rd
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus from time zero
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
   end
   // clear by one
   // Request changes just after an edge and stands until the next one
   task automatic xfer(input logic w, input logic r, input logic [7:0] a,
                       input logic [7:0] d);
      @(posedge clk);
      #1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, r, a, d};
   endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the status and event mask block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // **********
   // Bench state
   // **********
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       otp = 1'b1;
   logic       ce = 1'b1;
   logic [5:0] st = 6'h00;
   logic [4:0] ev = 5'h00;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       reg_wr, reg_rd, irq;
   int         error_cnt = 0;
   int         tests_run = 0;
   int         cyc = 0;
   int         bpos[4] = '{0, 2, 4, 7};
   logic [5:0] pat[4] = '{6'h3f, 6'h2a, 6'h15, 6'h00};
   reg_host host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
   regulator_status_and_event_masks DUT (.clk, .rstn, .ce,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
      .linreg1_enabled(st[5]), .linreg1_voltage_invalid(st[4]),
      .linreg1_current_limited(st[3]), .linreg0_enabled(st[2]),
      .linreg0_voltage_invalid(st[1]), .linreg0_current_limited(st[0]),
      .powergood_pin_event(ev[3]), .sync_clk_event(ev[2]),
      .thermal_warn_event(ev[1]), .load_meas_event(ev[0]),
      .reg_reset_req(ev[4]), .otp_regrst_mask(otp));
   // Clock, and a cycle ceiling well above the roughly 120 needed
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      host.xfer(1'b0, 1'b1, a, 8'h00);
      host.xfer(1'b0, 1'b0, a, 8'h00);
      check(reg_rdata, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, 1'b0, a, d);
      host.xfer(1'b0, 1'b0, a, d);
   endtask
   // Back-to-back clears of both flag bytes, then two cycles for irq
   task automatic clear_all();
      host.xfer(1'b1, 1'b0, regmask_pkg::ADDR_FLAGS_A, 8'hff);
      host.xfer(1'b1, 1'b0, regmask_pkg::ADDR_FLAGS_B, 8'hff);
      repeat (2) host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   // One-cycle event, returns once irq has had time to follow
   task automatic pulse(input int i);
      @(posedge clk);
      #1 ev[i] = 1'b1;
      @(posedge clk);
      #1 ev = 5'h00;
      @(posedge clk);
      #1;
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // **********
   // Test sequence
   // **********
   initial begin
      repeat (5) @(posedge clk);
      #1 rstn = 1'b1;
      rd(8'h1f, 8'h00);
      rd(8'h20, 8'h90);
      rd(8'h21, 8'h01);
      rd(8'h55, regmask_pkg::UNMAPPED_DATA);
      $display("reset values done");
      wr(8'h20, 8'hff);
      for (int k = 0; k < 4; k++) begin
         pulse(k);
         check({7'h00, irq}, 8'h00);
      end
      clear_all();
      // Status keeps tracking with every mask set; writes are ignored
      for (int k = 0; k < 4; k++) begin
         st = pat[k];
         wr(8'h1f, 8'hff);
         rd(8'h1f, {pat[k][5:4], 1'b0, pat[k][3:1], 1'b0, pat[k][0]});
      end
      $display("masked events and status done");
      wr(8'h20, 8'h00);
      for (int k = 0; k < 4; k++) begin
         pulse(k);
         check({7'h00, irq}, 8'h01);
         rd(regmask_pkg::ADDR_FLAGS_A, 8'h01 << bpos[k]);
         clear_all();
         check({7'h00, irq}, 8'h00);
      end
      wr(8'h20, 8'h6a);
      rd(8'h20, 8'h6a);
      // Clock enable low: an unmasked event must leave no flag behind
      ce = 1'b0;
      pulse(1);
      ce = 1'b1;
      check({7'h00, irq}, 8'h00);
      rd(regmask_pkg::ADDR_FLAGS_A, 8'h00);
      $display("unmasked events done");
      otp = 1'b0;
      pulse(4);
      check({7'h00, irq}, 8'h00);
      rd(8'h20, 8'h90);
      rd(8'h21, 8'h00);
      pulse(4);
      check({7'h00, irq}, 8'h01);
      rd(regmask_pkg::ADDR_FLAGS_B, 8'h01);
      clear_all();
      check({7'h00, irq}, 8'h00);
      $display("register reset done");
      wr(8'h21, 8'h01);
      rstn = 1'b0;
      repeat (5) @(posedge clk);
      #1 rstn = 1'b1;
      rd(8'h21, 8'h00);
      rd(8'h20, 8'h90);
      $display("second reset done");
      end_of_test();
   end
endmodule
bind regulator_status_and_event_masks rs_mon mon (.clk, .rstn, .ce, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .linreg1_enabled,
   .linreg0_enabled, .linreg1_voltage_invalid, .linreg0_voltage_invalid,
   .linreg1_current_limited, .linreg0_current_limited, .powergood_pin_event,
   .sync_clk_event, .thermal_warn_event, .load_meas_event, .reg_reset_req,
   .otp_regrst_mask);
`default_nettype wire
